// [include/afd_pkg.sv]
`default_nettype none
package afd_pkg;
   localparam int NCH = 2;
   // core clock rate and the time base derived from it
   localparam int unsigned CORE_FREQ_KHZ = 200000;
   localparam int unsigned TICK_TIME_MS = 1;
   localparam int unsigned TICK_CYCLES = TICK_TIME_MS * CORE_FREQ_KHZ;
   localparam int unsigned DIAG_TIME_MS = 100;
   localparam int unsigned ACQ_TIME_MS = 100;
   localparam logic [6:0] DIAG_TICKS = 7'(DIAG_TIME_MS / TICK_TIME_MS);
   localparam logic [6:0] ACQ_TICKS = 7'(ACQ_TIME_MS / TICK_TIME_MS);
   localparam logic [1:0] AC_MIN_PULSES = 2'h3;
   // first_instruction_byte fields
   localparam int IB1_DIAG_EN = 6;
   localparam int IB1_OFFS_EN = 5;
   localparam int IB1_GAIN_LOW = 4;
   localparam int IB1_UNMUTE = 2;
   // second_instruction_byte fields
   localparam int IB2_THR_LOW = 7;
   localparam int IB2_STBY_OFF = 4;
   localparam int IB2_LINE_MODE = 3;
   localparam int IB2_CD_EN = 2;
   localparam int IB2_HE_MODE = 1;
   // diagnostic byte fields
   localparam int DB_HI = 7;
   localparam int DB_MID = 6;
   localparam int DB_CD_OPEN = 5;
   localparam int DB_PERM = 4;
   localparam int DB_SHORT_LOAD = 3;
   localparam int DB_OPEN_OFFS = 2;
   localparam int DB_SHORT_VS = 1;
   localparam int DB_SHORT_GND = 0;
   localparam logic [7:0] IB_RESET = 8'h00;
   localparam logic [7:0] DB_RESET = 8'h00;
   typedef enum logic [1:0] {
      SEQ_STANDBY = 2'b00,
      SEQ_PULSE = 2'b01,
      SEQ_ACTIVE = 2'b10
   } afd_seq_t;
   typedef enum logic [1:0] {
      CH_RUN = 2'b00,
      CH_CHECK = 2'b01,
      CH_DIAG = 2'b10,
      CH_RESTART = 2'b11
   } afd_ch_t;
endpackage
`default_nettype wire

// [include/afd_chan_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface afd_chan_if;
   logic tick;
   logic overload;
   logic diag_en;
   logic armed;
   logic active;
   logic busy;
   logic done;
   modport ctl (output tick, output overload, output diag_en,
      output armed, input active, input busy, input done);
   modport chan (input tick, input overload, input diag_en,
      input armed, output active, output busy, output done);
endinterface
`default_nettype wire

// [core/afd_tick.sv]
`timescale 1ns/1ps
`default_nettype none
module afd_tick #(
   parameter int unsigned PERIOD = 200000
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   output logic tick
);
   localparam int W = $clog2(PERIOD);
   logic [W-1:0] cnt;
   wire at_end = cnt == W'(PERIOD - 1);

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         cnt <= '0;
      else if (clk_en)
         cnt <= at_end ? '0 : cnt + 1'b1;
   end

   assign tick = at_end & clk_en;
endmodule
`default_nettype wire

// [core/afd_chan.sv]
`timescale 1ns/1ps
`default_nettype none
module afd_chan
   import afd_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   afd_chan_if.chan cif
);
   afd_ch_t state;
   afd_ch_t next_state;
   logic [6:0] cnt;
   logic [6:0] next_cnt;
   wire cnt_end = cnt == DIAG_TICKS - 7'h01;

   always_comb
   begin
      next_state = state;
      next_cnt = cnt;
      case (state)
         CH_RUN:
            if (cif.overload)
            begin
               // analysis only when enabled and the last result was read
               next_state = (cif.diag_en && cif.armed) ? CH_CHECK
                  : CH_RESTART;
               next_cnt = 7'h00;
            end
         CH_CHECK:
            // tick phase is free running: the first tick only starts
            // the full 1 ms wait, so a late spike is never checked early
            if (cif.tick && cnt == 7'h00)
               next_cnt = 7'h01;
            else if (cif.tick)
            begin
               // a spike that has gone after 1 ms is not analysed
               next_state = cif.overload ? CH_DIAG : CH_RUN;
               next_cnt = 7'h00;
            end
         CH_DIAG:
            if (cif.tick)
            begin
               if (cnt_end)
                  next_state = CH_RESTART;
               else
                  next_cnt = cnt + 7'h01;
            end
         CH_RESTART:
            if (cif.tick && !cif.overload)
               next_state = CH_RUN;
         default:
            next_state = CH_RUN;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state <= CH_RUN;
         cnt <= 7'h00;
      end
      else if (clk_en)
      begin
         state <= next_state;
         cnt <= next_cnt;
      end
   end

   assign cif.active = state == CH_RUN;
   assign cif.busy = state == CH_CHECK || state == CH_DIAG;
   assign cif.done = state == CH_DIAG && cif.tick && cnt_end;
endmodule
`default_nettype wire

// [core/afd_diag.sv]
`timescale 1ns/1ps
`default_nettype none
module afd_diag
   import afd_pkg::*;
#(
   parameter int unsigned MS_CYCLES = TICK_CYCLES
) (
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic CLK_EN,
   input wire logic WR_STB,
   input wire logic [7:0] FIRST_INSTR_BYTE,
   input wire logic [7:0] SECOND_INSTR_BYTE,
   input wire logic RD_STB,
   output logic [7:0] DIAG_BYTE1,
   output logic [7:0] DIAG_BYTE2,
   input wire logic [1:0] SHORT_GND,
   input wire logic [1:0] SHORT_VS,
   input wire logic [1:0] SHORT_LOAD,
   input wire logic [1:0] OPEN_LOAD,
   input wire logic [1:0] OVERLOAD,
   input wire logic [1:0] OFFSET_HIGH,
   input wire logic [1:0] CUR_PULSE,
   input wire logic THERMAL_WARN,
   output logic TEST_PULSE,
   output logic STAGE_BIASED,
   output logic [1:0] CH_ACTIVE,
   output logic LINE_THRESHOLDS,
   output logic CD_THR_LOW,
   output logic GAIN_LOW,
   output logic UNMUTE,
   output logic HE_MODE
);
   // clear, then load the lanes in ld; the load wins over the clear
   function automatic logic [1:0] upd(
      input logic [1:0] old,
      input logic clr,
      input logic [1:0] ld,
      input logic [1:0] val
   );
      upd = ((clr ? 2'b00 : old) & ~ld) | (ld & val);
   endfunction

   function automatic logic [7:0] pack(
      input logic hi,
      input logic mid,
      input logic cd_open,
      input logic perm,
      input logic sload,
      input logic open_offs,
      input logic svs,
      input logic sgnd
   );
      pack = DB_RESET;
      pack[DB_HI] = hi;
      pack[DB_MID] = mid;
      pack[DB_CD_OPEN] = cd_open;
      pack[DB_PERM] = perm;
      pack[DB_SHORT_LOAD] = sload;
      pack[DB_OPEN_OFFS] = open_offs;
      pack[DB_SHORT_VS] = svs;
      pack[DB_SHORT_GND] = sgnd;
   endfunction

   // all analog sense lines are asynchronous to the core clock
   logic [14:0] sync1;
   logic [14:0] sync2;
   wire [14:0] raw_in = {THERMAL_WARN, CUR_PULSE, OFFSET_HIGH, OVERLOAD,
      OPEN_LOAD, SHORT_LOAD, SHORT_VS, SHORT_GND};

   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         sync1 <= '0;
         sync2 <= '0;
      end
      else if (CLK_EN)
      begin
         sync1 <= raw_in;
         sync2 <= sync1;
      end
   end

   wire [1:0] s_gnd = sync2[1:0];
   wire [1:0] s_vs = sync2[3:2];
   wire [1:0] s_load = sync2[5:4];
   wire [1:0] s_open = sync2[7:6];
   wire [1:0] s_ovl = sync2[9:8];
   wire [1:0] s_offs = sync2[11:10];
   wire [1:0] s_pulse = sync2[13:12];
   wire s_therm = sync2[14];

   // host instruction bytes
   logic [7:0] ib1;
   logic [7:0] ib2;

   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         ib1 <= IB_RESET;
         ib2 <= IB_RESET;
      end
      else if (CLK_EN && WR_STB)
      begin
         ib1 <= FIRST_INSTR_BYTE;
         ib2 <= SECOND_INSTR_BYTE;
      end
   end

   wire wr_stby_exit = WR_STB && !ib2[IB2_STBY_OFF]
      && SECOND_INSTR_BYTE[IB2_STBY_OFF];
   wire wr_stby_entry = WR_STB && ib2[IB2_STBY_OFF]
      && !SECOND_INSTR_BYTE[IB2_STBY_OFF];
   wire wr_diag_en = FIRST_INSTR_BYTE[IB1_DIAG_EN];
   wire offs_on = ib1[IB1_OFFS_EN];
   wire cd_on = ib2[IB2_CD_EN];
   wire offs_start = (WR_STB && !offs_on && FIRST_INSTR_BYTE[IB1_OFFS_EN])
      || (RD_STB && offs_on);
   wire offs_stop = WR_STB && !FIRST_INSTR_BYTE[IB1_OFFS_EN];
   wire cd_start = (WR_STB && !cd_on && SECOND_INSTR_BYTE[IB2_CD_EN])
      || (RD_STB && cd_on);
   wire cd_stop = WR_STB && !SECOND_INSTR_BYTE[IB2_CD_EN];

   logic tick;

   afd_tick #(
      .PERIOD(MS_CYCLES)
   ) u_tick (
      .clk(CORE_CLK),
      .rst_n(RST_N),
      .clk_en(CLK_EN),
      .tick(tick)
   );

   // turn-on sequencer
   afd_seq_t seq;
   afd_seq_t next_seq;
   logic [6:0] acq_cnt;
   logic [6:0] next_acq_cnt;
   logic ton_armed;
   wire acq_end = acq_cnt == ACQ_TICKS - 7'h01;
   wire ton_done = seq == SEQ_PULSE && tick && acq_end && !wr_stby_entry;
   wire biased = seq == SEQ_ACTIVE;

   always_comb
   begin
      next_seq = seq;
      next_acq_cnt = acq_cnt;
      case (seq)
         SEQ_STANDBY:
            if (wr_stby_exit)
            begin
               // pulse runs with the stage still unbiased
               if (wr_diag_en && ton_armed)
               begin
                  next_seq = SEQ_PULSE;
                  next_acq_cnt = 7'h00;
               end
               else
                  next_seq = SEQ_ACTIVE;
            end
         SEQ_PULSE:
            if (wr_stby_entry)
               next_seq = SEQ_STANDBY;
            else if (tick)
            begin
               if (acq_end)
                  next_seq = SEQ_ACTIVE;
               else
                  next_acq_cnt = acq_cnt + 7'h01;
            end
         SEQ_ACTIVE:
            if (wr_stby_entry)
               next_seq = SEQ_STANDBY;
         default:
            next_seq = SEQ_STANDBY;
      endcase
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         seq <= SEQ_STANDBY;
         acq_cnt <= 7'h00;
         ton_armed <= 1'b1;
      end
      else if (CLK_EN)
      begin
         seq <= next_seq;
         acq_cnt <= next_acq_cnt;
         // a new pulse only after the previous result was read
         ton_armed <= RD_STB | (ton_armed & ~ton_done);
      end
   end

   // permanent diagnostics, one engine per channel
   afd_chan_if cif [NCH] ();
   logic [1:0] perm_armed;
   logic [1:0] ch_done;
   logic [1:0] ch_run;

   for (genvar g = 0; g < NCH; g++)
   begin : g_ch
      // overloads are ignored until the stage is biased
      assign cif[g].tick = tick;
      assign cif[g].overload = s_ovl[g] & biased;
      assign cif[g].diag_en = ib1[IB1_DIAG_EN];
      assign cif[g].armed = perm_armed[g];
      assign ch_done[g] = cif[g].done;
      assign ch_run[g] = cif[g].active;

      afd_chan u_chan (
         .clk(CORE_CLK),
         .rst_n(RST_N),
         .clk_en(CLK_EN),
         .cif(cif[g])
      );
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
         perm_armed <= 2'b11;
      else if (CLK_EN)
         perm_armed <= {2{RD_STB}} | (perm_armed & ~ch_done);
   end

   // live results of the last finished cycle, cleared by each read
   logic [1:0] lv_gnd;
   logic [1:0] lv_vs;
   logic [1:0] lv_load;
   logic [1:0] lv_open;
   logic [1:0] lv_perm;
   logic [1:0] lv_term;
   wire [1:0] ton_lanes = {2{ton_done}};
   wire [1:0] ld = ch_done | ton_lanes;

   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         lv_gnd <= 2'b00;
         lv_vs <= 2'b00;
         lv_load <= 2'b00;
         lv_open <= 2'b00;
         lv_perm <= 2'b00;
         lv_term <= 2'b00;
      end
      else if (CLK_EN)
      begin
         // each finished cycle overwrites its lanes, so only faults of the last cycle show, several at once
         lv_gnd <= upd(lv_gnd, RD_STB, ld, s_gnd);
         lv_vs <= upd(lv_vs, RD_STB, ld, s_vs);
         lv_load <= upd(lv_load, RD_STB, ld, s_load);
         lv_open <= upd(lv_open, RD_STB, ld, ton_lanes & s_open);
         lv_perm <= upd(lv_perm, RD_STB, ld, ~ton_lanes);
         lv_term <= upd(lv_term, RD_STB, ld, 2'b11);
      end
   end

   // offset window: any gap in the high-offset level spoils it
   logic offs_win;
   logic [1:0] offs_ok;
   logic [1:0] offs_abort;

   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         offs_win <= 1'b0;
         offs_ok <= 2'b00;
         offs_abort <= 2'b00;
      end
      else if (CLK_EN)
      begin
         if (offs_stop)
            offs_win <= 1'b0;
         else if (offs_start)
         begin
            offs_win <= 1'b1;
            offs_ok <= 2'b11;
            offs_abort <= 2'b00;
         end
         else if (offs_win)
         begin
            offs_ok <= offs_ok & s_offs;
            offs_abort <= offs_abort | s_ovl;
         end
      end
   end

   wire [1:0] offs_flag = {2{offs_win}} & offs_ok & ~offs_abort;

   // AC load test: count current pulses above threshold
   logic [1:0] pulse_prev;
   logic [1:0] cd_cnt [NCH];
   logic [1:0] cd_abort;
   wire [1:0] pulse_rise = s_pulse & ~pulse_prev;

   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
         pulse_prev <= 2'b00;
      else if (CLK_EN)
         pulse_prev <= s_pulse;
   end

   for (genvar g = 0; g < NCH; g++)
   begin : g_cd
      wire sat = cd_cnt[g] == AC_MIN_PULSES;

      always_ff @(posedge CORE_CLK)
      begin
         if (!RST_N)
         begin
            cd_cnt[g] <= 2'b00;
            cd_abort[g] <= 1'b0;
         end
         else if (CLK_EN)
         begin
            if (cd_start)
            begin
               cd_cnt[g] <= 2'b00;
               cd_abort[g] <= 1'b0;
            end
            else if (cd_on)
            begin
               // saturates; more pulses add nothing
               if (pulse_rise[g] && !sat)
                  cd_cnt[g] <= cd_cnt[g] + 2'b01;
               cd_abort[g] <= cd_abort[g] | s_ovl[g];
            end
         end
      end
   end

   // an abandoned test reports no open tweeter
   wire [1:0] cd_open = {2{cd_on}} & ~cd_abort
      & {cd_cnt[1] != AC_MIN_PULSES, cd_cnt[0] != AC_MIN_PULSES};

   wire [1:0] d2 = offs_win ? offs_flag : lv_open;
   wire [7:0] db1 = pack(s_therm, lv_term[0], cd_open[0], lv_perm[0],
      lv_load[0], d2[0], lv_vs[0], lv_gnd[0]);
   wire [7:0] db2 = pack(offs_win, cd_on, cd_open[1], lv_perm[1],
      lv_load[1], d2[1], lv_vs[1], lv_gnd[1]);

   // bytes shown after a read were frozen at that read
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         DIAG_BYTE1 <= DB_RESET;
         DIAG_BYTE2 <= DB_RESET;
      end
      else if (CLK_EN && RD_STB)
      begin
         DIAG_BYTE1 <= db1;
         DIAG_BYTE2 <= db2;
      end
   end

   // pin-facing controls, all from flip-flops
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         TEST_PULSE <= 1'b0;
         STAGE_BIASED <= 1'b0;
         CH_ACTIVE <= 2'b00;
         LINE_THRESHOLDS <= 1'b0;
         CD_THR_LOW <= 1'b0;
         GAIN_LOW <= 1'b0;
         UNMUTE <= 1'b0;
         HE_MODE <= 1'b0;
      end
      else if (CLK_EN)
      begin
         TEST_PULSE <= next_seq == SEQ_PULSE;
         STAGE_BIASED <= next_seq == SEQ_ACTIVE;
         CH_ACTIVE <= ch_run & {2{biased}};
         // rail-short thresholds do not depend on this
         LINE_THRESHOLDS <= ib1[IB1_GAIN_LOW] & ib2[IB2_LINE_MODE];
         CD_THR_LOW <= ib2[IB2_THR_LOW];
         GAIN_LOW <= ib1[IB1_GAIN_LOW];
         UNMUTE <= ib1[IB1_UNMUTE];
         HE_MODE <= ib2[IB2_HE_MODE];
      end
   end
endmodule
`default_nettype wire

// [bench/afd_diag_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module afd_diag_monitor
   import afd_pkg::*;
#(
   parameter int unsigned MS_CYCLES = TICK_CYCLES
) (
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic CLK_EN,
   input wire logic WR_STB,
   input wire logic [7:0] FIRST_INSTR_BYTE,
   input wire logic [7:0] SECOND_INSTR_BYTE,
   input wire logic RD_STB,
   input wire logic [7:0] DIAG_BYTE1,
   input wire logic [7:0] DIAG_BYTE2,
   input wire logic [1:0] OVERLOAD,
   input wire logic TEST_PULSE,
   input wire logic STAGE_BIASED,
   input wire logic [1:0] CH_ACTIVE,
   input wire logic LINE_THRESHOLDS,
   input wire logic CD_THR_LOW,
   input wire logic GAIN_LOW
);
   localparam int REC_MAX = MS_CYCLES + 8;
   localparam int unsigned P_LO = (int'(ACQ_TICKS) - 1) * MS_CYCLES;
   localparam int unsigned P_HI = (int'(ACQ_TICKS) + 1) * MS_CYCLES;
   int unsigned pulse_cnt;
   wire logic pulse_req;
   // tick phase is free running, so the pulse length has one tick slack
   assign pulse_req = WR_STB && FIRST_INSTR_BYTE[IB1_DIAG_EN]
      && SECOND_INSTR_BYTE[IB2_STBY_OFF];
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N || !TEST_PULSE)
         pulse_cnt <= 0;
      else if (CLK_EN)
         pulse_cnt <= pulse_cnt + 1;
   end
   default clocking mon_cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!RST_N);
   a_pulse_unbiased: assert property (TEST_PULSE |-> !STAGE_BIASED)
      else $error("test pulse with stage biased");
   a_pulse_cause: assert property ($rose(TEST_PULSE) |-> $past(pulse_req))
      else $error("test pulse without request");
   a_pulse_length: assert property ($fell(TEST_PULSE) |->
      pulse_cnt >= P_LO && pulse_cnt <= P_HI)
      else $error("test pulse length wrong");
   a_bias_after: assert property ($fell(TEST_PULSE) |-> STAGE_BIASED)
      else $error("no bias after test pulse");
   a_read_updates: assert property (!$stable(DIAG_BYTE1) ||
      !$stable(DIAG_BYTE2) |-> $past(RD_STB))
      else $error("result bytes changed without read");
   // pins follow the latched bytes, so they settle two edges after a write
   a_write_ctl: assert property (WR_STB && CLK_EN |=> ##1
      GAIN_LOW == $past(FIRST_INSTR_BYTE[IB1_GAIN_LOW], 2) &&
      CD_THR_LOW == $past(SECOND_INSTR_BYTE[IB2_THR_LOW], 2))
      else $error("control bits not taken from write");
   a_line_thr: assert property (WR_STB && CLK_EN |=> ##1
      LINE_THRESHOLDS == ($past(FIRST_INSTR_BYTE[IB1_GAIN_LOW], 2) &&
      $past(SECOND_INSTR_BYTE[IB2_LINE_MODE], 2)))
      else $error("line thresholds wrong");
   a_ovl_shuts: assert property (OVERLOAD[0] [*6] |-> !CH_ACTIVE[0])
      else $error("channel active under overload");
   a_restart_on: assert property (STAGE_BIASED &&
      !FIRST_INSTR_BYTE[IB1_DIAG_EN] && $fell(OVERLOAD[0])
      |-> ##[1:REC_MAX] CH_ACTIVE[0])
      else $error("channel not restarted");
   a_act_biased: assert property (CH_ACTIVE != 2'b00 |->
      $past(STAGE_BIASED))
      else $error("channel active while unbiased");
endmodule
bind afd_diag afd_diag_monitor #(.MS_CYCLES(MS_CYCLES)) u_mon (
   .CORE_CLK(CORE_CLK), .RST_N(RST_N), .CLK_EN(CLK_EN), .WR_STB(WR_STB),
   .FIRST_INSTR_BYTE(FIRST_INSTR_BYTE), .RD_STB(RD_STB),
   .SECOND_INSTR_BYTE(SECOND_INSTR_BYTE), .DIAG_BYTE1(DIAG_BYTE1),
   .DIAG_BYTE2(DIAG_BYTE2), .OVERLOAD(OVERLOAD), .TEST_PULSE(TEST_PULSE),
   .STAGE_BIASED(STAGE_BIASED), .CH_ACTIVE(CH_ACTIVE),
   .LINE_THRESHOLDS(LINE_THRESHOLDS), .CD_THR_LOW(CD_THR_LOW),
   .GAIN_LOW(GAIN_LOW));
`default_nettype wire

// [bench/afd_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module afd_host_model (
   input wire logic clk,
   output logic wr_stb,
   output logic rd_stb,
   output logic [7:0] ib1,
   output logic [7:0] ib2,
   output logic [1:0] cur_pulse
);
   initial
   begin
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      ib1 = 8'h00;
      ib2 = 8'h00;
      cur_pulse = 2'h0;
   end
   task automatic write(input logic [7:0] b1, input logic [7:0] b2);
      @(posedge clk);
      #1;
      wr_stb = 1'b1;
      ib1 = b1;
      ib2 = b2;
      @(posedge clk);
      #1;
      wr_stb = 1'b0;
   endtask
   task automatic read();
      @(posedge clk);
      #1;
      rd_stb = 1'b1;
      @(posedge clk);
      #1;
      rd_stb = 1'b0;
   endtask
   // burst of eight 125 ns periods, lane stays low outside it
   task automatic tone(input int n0, input int n1);
      for (int i = 0; i < 8; i++)
      begin
         #62.5;
         cur_pulse = {i < n1, i < n0};
         #62.5;
         cur_pulse = 2'h0;
      end
   endtask
endmodule
`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import afd_pkg::*;
;
   localparam int MS = 20;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   wire logic wr_stb, rd_stb, tpulse, biased, line_thr, thr_low, gain_low;
   wire logic unmute, he;
   wire logic [7:0] ib1, ib2, db1, db2;
   wire logic [1:0] cur, act;
   logic [1:0] sgnd = 2'h0, svs = 2'h0, sload = 2'h0, open_l = 2'h0;
   logic [1:0] ovl = 2'h0, offs = 2'h0;
   logic [7:0] b1, b2;
   int n_errors = 0;
   int samples_checked = 0;
   int live [2] = '{0, 0};
   // live window flags shown in the top bits of the second byte
   int hi2 = 0;
   int n0 [4] = '{3, 2, 0, 0};
   int n1 [4] = '{2, 3, 5, 0};
   int gl [4] = '{0, 0, 0, 1};
   int i, k;
   always #2.5 clk = ~clk;
   afd_host_model host (.clk(clk), .wr_stb(wr_stb), .rd_stb(rd_stb),
      .ib1(ib1), .ib2(ib2), .cur_pulse(cur));
   afd_diag #(.MS_CYCLES(MS)) uut (.CORE_CLK(clk), .RST_N(rst_n),
      .CLK_EN(1'b1), .WR_STB(wr_stb), .FIRST_INSTR_BYTE(ib1),
      .SECOND_INSTR_BYTE(ib2), .RD_STB(rd_stb), .DIAG_BYTE1(db1),
      .DIAG_BYTE2(db2), .SHORT_GND(sgnd), .SHORT_VS(svs),
      .SHORT_LOAD(sload), .OPEN_LOAD(open_l), .OVERLOAD(ovl),
      .OFFSET_HIGH(offs), .CUR_PULSE(cur), .THERMAL_WARN(1'b0),
      .TEST_PULSE(tpulse), .STAGE_BIASED(biased), .CH_ACTIVE(act),
      .LINE_THRESHOLDS(line_thr), .CD_THR_LOW(thr_low),
      .GAIN_LOW(gain_low), .UNMUTE(unmute), .HE_MODE(he));
   task automatic chk(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // model holds results gathered since the last read, then forgets them
   task automatic rd(input string what);
      host.read();
      chk({what, " b1"}, db1, 8'(live[0]));
      chk({what, " b2"}, db2, 8'(live[1] | hi2));
      live = '{0, 0};
   endtask
   task automatic glitch(input int ch);
      ovl[ch] = 1'b1;
      cyc(3);
      ovl[ch] = 1'b0;
   endtask
   task automatic test_done;
      $display("checked %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      #300000;
      n_errors++;
      test_done();
   end
   initial
   begin
      k = $urandom(28);
      cyc(2);
      rst_n = 1'b1;
      chk("reset b1", db1, DB_RESET);
      for (i = 0; i < 8; i++)
      begin
         b1 = 8'($urandom) & 8'h14;
         b2 = 8'($urandom) & 8'h8A;
         host.write(b1, b2);
         // control pins come from the latched bytes one cycle later
         cyc(1);
         chk("ctl", {3'h0, gain_low, unmute, he, thr_low, line_thr},
            {3'h0, b1[4], b1[2], b2[1], b2[7], b1[4] & b2[3]});
      end
      host.write(8'h00, 8'h10);
      chk("bias", {6'h0, tpulse, biased}, 8'h01);
      cyc(2);
      ovl = 2'b01;
      cyc(3 * MS);
      chk("restart off", {6'h0, act}, 8'h02);
      ovl = 2'b00;
      for (i = 0; i < MS + 10 && act !== 2'b11; i++) cyc(1);
      chk("restart on", {6'h0, act}, 8'h03);
      host.write(8'h00, 8'h00);
      chk("standby", {7'h0, biased}, 8'h00);
      rd("idle");
      sgnd = 2'b01;
      sload = 2'b10;
      open_l = 2'b10;
      host.write(8'h40, 8'h10);
      chk("pulse", {6'h0, tpulse, biased}, 8'h02);
      for (i = 0; i < 101 * MS && tpulse !== 1'b0; i++) cyc(1);
      chk("pulse end", {6'h0, tpulse, biased}, 8'h01);
      sgnd = 2'b00;
      sload = 2'b00;
      open_l = 2'b00;
      live = '{'h41, 'h0C};
      rd("turn-on");
      rd("turn-on again");
      glitch(0);
      cyc(3 * MS);
      chk("glitch", {6'h0, act}, 8'h03);
      ovl = 2'b10;
      svs = 2'b10;
      open_l = 2'b10;
      cyc(50 * MS);
      chk("diag off", {6'h0, act}, 8'h01);
      cyc(55 * MS);
      ovl = 2'b00;
      svs = 2'b00;
      open_l = 2'b00;
      for (i = 0; i < MS + 10 && act !== 2'b11; i++) cyc(1);
      chk("diag resume", {6'h0, act}, 8'h03);
      live[1] = 'h12;
      rd("permanent");
      offs = 2'b01;
      host.write(8'h60, 8'h10);
      hi2 = 'h80;
      cyc(10);
      offs = 2'b11;
      cyc(5);
      live[0] = 4;
      rd("offset");
      glitch(0);
      cyc(2 * MS);
      live[1] = 4;
      rd("offset ovl");
      offs = 2'b01;
      cyc(3);
      offs = 2'b11;
      cyc(5);
      live[0] = 4;
      rd("offset gap");
      offs = 2'b00;
      host.write(8'h40, 8'h14);
      hi2 = 'h40;
      for (k = 0; k < 4; k++)
      begin
         if (k == 2)
            host.write(8'h40, 8'h94);
         if (gl[k] != 0)
            glitch(0);
         host.tone(n0[k], n1[k]);
         cyc(2 * MS);
         live[0] = (n0[k] < 3 && gl[k] == 0) ? 'h20 : 0;
         live[1] = n1[k] < 3 ? 'h20 : 0;
         rd("ac");
      end
      test_done();
   end
endmodule
`default_nettype wire
